// [hdl/loop_filter_pkg.sv]
// Package: offsets, field layout and reset values of the output loop filter and divider registers
package loop_filter_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_SELECT = 12'h0f5;
  localparam logic [ADDR_W-1:0] ADDR_BYPASS = 12'h0f6;
  localparam logic [ADDR_W-1:0] ADDR_DIVIDER = 12'h0f7;
  localparam int POLE2_LSB = 6;
  localparam int ZERO_LSB = 3;
  localparam int CAP_LSB = 0;
  localparam int BYPASS_BIT = 0;
  localparam int DIV_W = 5;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic BYPASS_RESET = 1'b0;
  localparam logic [DIV_W-1:0] DIVIDER_RESET = 5'h01;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : loop_filter_pkg

// [hdl/pll_loop_filter_divider_regs.sv]
// Output loop filter selection and reference divider register slice
`timescale 1ns/1ps

// Summary of operation
// [R1] Pole 2 code selects 900/450/300/225 ohms
// [R2] Zero code selects one of eight resistances
// [R3] Pole 1 code selects 0..48 pF, duplicates
// [R4] Bypass bit forces zero resistor to zero
// [R5] Bypass bit is MSB of 9-bit control
// [R6] Divider ratio 1..31, zero means one
// [R7] Reserved bits ignore writes, read zero
module pll_loop_filter_divider_regs
  import loop_filter_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [8:0] o_loop_filter_ctrl,
  output logic [11:0] o_second_pole_resistor_ohm,
  output logic [11:0] o_zero_resistor_ohm,
  output logic [5:0] o_first_pole_capacitor_pf,
  output logic o_zero_bypass,
  output logic [DIV_W-1:0] o_loop_reference_divider_ratio
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] loop_filter_select;
  logic loop_filter_bypass;
  logic [DIV_W-1:0] loop_reference_divider;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      loop_filter_select <= SELECT_RESET;
    end else if (i_wr && i_addr == ADDR_SELECT) begin
      loop_filter_select <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      loop_filter_bypass <= BYPASS_RESET;
    end else if (i_wr && i_addr == ADDR_BYPASS) begin
      loop_filter_bypass <= i_wdata[BYPASS_BIT]; // see [R7]
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      loop_reference_divider <= DIVIDER_RESET;
    end else if (i_wr && i_addr == ADDR_DIVIDER) begin
      loop_reference_divider <= i_wdata[DIV_W-1:0]; // see [R7]
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= UNMAPPED_READ;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_SELECT: o_rdata <= loop_filter_select;
        ADDR_BYPASS: o_rdata <= {7'h00, loop_filter_bypass}; // see [R7]
        ADDR_DIVIDER: o_rdata <= {3'h0, loop_reference_divider}; // see [R7]
        default: o_rdata <= UNMAPPED_READ;
      endcase
    end else begin
      o_rdata <= UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  logic [1:0] pole2_code;
  logic [2:0] zero_code;
  logic [2:0] cap_code;
  logic [11:0] next_pole2;
  logic [11:0] next_zero;
  logic [5:0] next_cap;
  logic [DIV_W-1:0] next_ratio;

  assign pole2_code = loop_filter_select[POLE2_LSB +: 2];
  assign zero_code = loop_filter_select[ZERO_LSB +: 3];
  assign cap_code = loop_filter_select[CAP_LSB +: 3];

  always_comb begin
    case (pole2_code) // see [R1]
      2'h0: next_pole2 = 12'h384;
      2'h1: next_pole2 = 12'h1c2;
      2'h2: next_pole2 = 12'h12c;
      default: next_pole2 = 12'h0e1;
    endcase
  end

  always_comb begin
    if (loop_filter_bypass) begin
      next_zero = 12'h000; // see [R4]
    end else begin
      case (zero_code) // see [R2]
        3'h0: next_zero = 12'hcb2;
        3'h1: next_zero = 12'habe;
        3'h2: next_zero = 12'h8ca;
        3'h3: next_zero = 12'h834;
        3'h4: next_zero = 12'hbb8;
        3'h5: next_zero = 12'h9c4;
        3'h6: next_zero = 12'h7d0;
        default: next_zero = 12'h73a;
      endcase
    end
  end

  always_comb begin
    case (cap_code) // see [R3]
      3'h0: next_cap = 6'h00;
      3'h1: next_cap = 6'h08;
      3'h2: next_cap = 6'h10;
      3'h3: next_cap = 6'h18;
      3'h4: next_cap = 6'h18;
      3'h5: next_cap = 6'h20;
      3'h6: next_cap = 6'h28;
      default: next_cap = 6'h30;
    endcase
  end

  always_comb begin
    if (loop_reference_divider == 5'h00) begin
      next_ratio = 5'h01; // see [R6]
    end else begin
      next_ratio = loop_reference_divider;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered decoded controls

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_second_pole_resistor_ohm <= 12'h384;
      o_zero_resistor_ohm <= 12'hcb2;
      o_first_pole_capacitor_pf <= 6'h00;
      o_zero_bypass <= 1'b0;
      o_loop_filter_ctrl <= 9'h000;
      o_loop_reference_divider_ratio <= 5'h01;
    end else begin
      o_second_pole_resistor_ohm <= next_pole2;
      o_zero_resistor_ohm <= next_zero;
      o_first_pole_capacitor_pf <= next_cap;
      o_zero_bypass <= loop_filter_bypass; // see [R4]
      o_loop_filter_ctrl <= {loop_filter_bypass, loop_filter_select}; // see [R5]
      o_loop_reference_divider_ratio <= next_ratio;
    end
  end

endmodule : pll_loop_filter_divider_regs

// [bench/loop_filter_regs_asserts.sv]
// Checker: decode and read-back properties of the loop filter registers
`timescale 1ns/1ps
module loop_filter_regs_asserts
  import loop_filter_pkg::*;
(
  input wire logic i_clk_sys, i_rst, i_wr, i_rd, o_zero_bypass,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic [8:0] o_loop_filter_ctrl,
  input wire logic [11:0] o_second_pole_resistor_ohm, o_zero_resistor_ohm,
  input wire logic [5:0] o_first_pole_capacitor_pf,
  input wire logic [DIV_W-1:0] o_loop_reference_divider_ratio
);
  localparam int ZT[8] = '{3250, 2750, 2250, 2100, 3000, 2500, 2000, 1850};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  pole2_decode_a: assert property (o_second_pole_resistor_ohm *
    (o_loop_filter_ctrl[7:6] + 1) == 900) else $error("pole 2 decode");
  zero_decode_a: assert property (o_zero_resistor_ohm ==
    (o_zero_bypass ? 0 : ZT[o_loop_filter_ctrl[5:3]])) else $error("zero decode");
  cap_decode_a: assert property (o_first_pole_capacitor_pf == 8 *
    (o_loop_filter_ctrl[2:0] - (o_loop_filter_ctrl[2:0] > 3))) else $error("cap decode");
  bypass_msb_a: assert property (o_zero_bypass == o_loop_filter_ctrl[8])
    else $error("bypass msb");
  divider_ratio_a: assert property (i_wr && i_addr == ADDR_DIVIDER |-> ##2
    o_loop_reference_divider_ratio == (($past(i_wdata, 2) & 8'h1f) |
    (($past(i_wdata, 2) & 8'h1f) == 0))) else $error("divider ratio");
  reserved_zero_a: assert property (i_rd && i_addr == ADDR_BYPASS |=>
    o_rdata[7:1] == 0) else $error("reserved bits");
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 0) else $error("read idle");
endmodule : loop_filter_regs_asserts

bind pll_loop_filter_divider_regs loop_filter_regs_asserts u_chk (.*);

// [bench/tb_pll_loop_filter_divider_regs.sv]
// Testbench: register access and decode checks of the loop filter slice
`timescale 1ns/1ps
module tb_pll_loop_filter_divider_regs
  import loop_filter_pkg::*;
;
  logic i_clk_sys = 0, i_rst = 1, i_wr = 0, i_rd = 0, o_zero_bypass;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [7:0] i_wdata = '0, o_rdata;
  logic [8:0] o_loop_filter_ctrl;
  logic [11:0] o_second_pole_resistor_ohm, o_zero_resistor_ohm;
  logic [5:0] o_first_pole_capacitor_pf;
  logic [DIV_W-1:0] o_loop_reference_divider_ratio;
  int fails = 0, comparisons = 0, cyc = 0;
  pll_loop_filter_divider_regs dut (.*);
  always #50 i_clk_sys = ~i_clk_sys;
  task chk(input logic [11:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys) i_wr <= 0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_clk_sys) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys) i_rd <= 0;
    #1 chk(o_rdata, e);
  endtask : rd
  task end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 500) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 0;
    rd(ADDR_SELECT, 8'h00);
    rd(ADDR_DIVIDER, 8'h01);
    $display("reset test done");
    wr(ADDR_SELECT, 8'hdb);
    wr(12'h0f4, 8'hff);
    rd(ADDR_SELECT, 8'hdb);
    chk(o_second_pole_resistor_ohm, 225);
    chk(o_zero_resistor_ohm, 2100);
    chk(o_first_pole_capacitor_pf, 24);
    wr(ADDR_BYPASS, 8'hff);
    rd(ADDR_BYPASS, 8'h01);
    chk(o_zero_resistor_ohm, 0);
    chk(o_zero_bypass, 1);
    chk(o_loop_filter_ctrl, 12'h1db);
    wr(ADDR_SELECT, 8'h64);
    wr(ADDR_BYPASS, 8'h00);
    rd(ADDR_SELECT, 8'h64);
    chk(o_zero_resistor_ohm, 3000);
    chk(o_zero_bypass, 0);
    $display("filter test done");
    wr(ADDR_DIVIDER, 8'hff);
    rd(ADDR_DIVIDER, 8'h1f);
    chk(o_loop_reference_divider_ratio, 31);
    wr(ADDR_DIVIDER, 8'h00);
    rd(12'h0f8, 8'h00);
    chk(o_loop_reference_divider_ratio, 1);
    $display("divider test done");
    end_of_test;
  end
endmodule : tb_pll_loop_filter_divider_regs
